/* File: src/node_processor_register_port.sv */
// Register port of the physical layer controller: processor bus cycles,
// the register map, access checks, clear-on-read counters and control A.
// Assumes the processor bus is synchronous to i_mclk and that the other
// status words and event strobes come from logic on the same clock.
`timescale 1ns/1ns

// Contract
// - Illegal write sets access error, register unchanged
// - Write data captured second edge after select
// - One write per select assertion
// - Twenty-seven 16-bit registers at 00 to 1A
// - Event register and counters clear on read
// - Signal bit registers writable only when idle
// - Phase timer load only in service state
// - Noise load needs service state, timing off
// - Reset clears control register A
// - Restricted control bits frozen outside off/service
// - Noise timer loads on leaving idle, expiry event
// - Bit 13 bypasses noise prescaler, 80 ns
// - Bit 12 bypasses phase prescaler, 80 ns
// - Bit 11 scrubs receive bytes to Idle in service state or with path override
// - Bit 10 enables even parity check
// - Bit 9 violation event only on overflow
// - Bit 8 gap event only on overflow
// - Bit 7 drives wrap select low
// - Select sampled on edge, address and direction captured
module node_processor_register_port
(
	input  wire logic                       i_mclk,
	input  wire logic                       i_resetn,
	input  wire logic                       i_cs_n,
	input  wire logic                       i_read_write_select,
	input  wire logic [npr_pkg::ADDR_W-1:0] i_processor_address,
	input  wire logic [npr_pkg::DATA_W-1:0] i_processor_data_bus,
	output logic      [npr_pkg::DATA_W-1:0] o_processor_data_bus,
	output logic                            o_processor_data_oe_n,
	input  wire npr_pkg::conn_state_t       i_conn,
	input  wire npr_pkg::ro_inputs_t        i_ro,
	input  wire logic [2:0]                 i_line_state,
	input  wire logic                       i_unknown_line_state,
	input  wire logic                       i_violation_strobe,
	input  wire logic                       i_gap_strobe,
	input  wire logic                       i_link_error_strobe,
	input  wire logic                       i_tx_valid,
	input  wire logic [9:0]                 i_tx_byte,
	output logic      [npr_pkg::DATA_W-1:0] o_control_a,
	output logic                            o_rx_idle,
	output logic                            o_wrap_select_n
);
	import npr_pkg::*;

	bus_state_t        state;
	logic [ADDR_W-1:0] addr;
	logic              rw;
	logic              do_op;
	logic              wr_op;
	logic              rd_op;
	logic              wr_ok;
	logic              wr_err;
	logic              mem_target;
	logic              mem_we;
	logic [MEM_AW-1:0] mem_addr;
	logic [DATA_W-1:0] mem_rdata;
	logic [DATA_W-1:0] read_value;
	logic [DATA_W-1:0] control_a;
	logic [DATA_W-1:0] ca_keep;
	logic [DATA_W-1:0] event_flags;
	logic [DATA_W-1:0] event_set;
	logic [DATA_W-1:0] violation_count;
	logic [DATA_W-1:0] idle_gap_count;
	logic [DATA_W-1:0] link_error_count;
	logic [DATA_W-1:0] max_noise_time;
	logic [DATA_W-1:0] noise_event_timer;
	logic [DATA_W-1:0] connection_phase_timer;
	logic [3:0]        tick_cnt;
	logic              tick;
	logic [NOISE_PRE_W-1:0] noise_pre;
	logic [PHASE_PRE_W-1:0] phase_pre;
	logic              noise_step;
	logic              phase_step;
	logic              noise_run;
	logic              line_idle;
	logic              prev_idle;
	logic              leave_idle;
	logic              noise_armed;
	logic              noise_expire;

	// ----------------------------------------------------------------
	// Processor bus cycle
	// ----------------------------------------------------------------
	// Address and direction are caught on the edge that sees select low;
	// the access itself happens on the next edge, exactly once.
	always_ff @(posedge i_mclk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			state <= BUS_IDLE;
			addr  <= 5'h00;
			rw    <= 1'b1;
		end
		else
		begin
			case (state)
				BUS_IDLE:
					if (!i_cs_n)
					begin
						state <= BUS_ACCESS;
						addr  <= i_processor_address;
						rw    <= i_read_write_select;
					end
				BUS_ACCESS:
					state <= i_cs_n ? BUS_TAIL : BUS_HELD;
				BUS_HELD:
					if (i_cs_n)
						state <= BUS_TAIL;
				BUS_TAIL:
					state <= BUS_IDLE;
				default:
					state <= BUS_IDLE;
			endcase
		end
	end

	assign do_op = (state == BUS_ACCESS);
	assign wr_op = do_op && !rw;
	assign rd_op = do_op && rw;

	// Data bus drive window: from the select edge to the first edge
	// after select is seen high again
	always_ff @(posedge i_mclk or negedge i_resetn)
	begin
		if (!i_resetn)
			o_processor_data_oe_n <= 1'b1;
		else if (state == BUS_IDLE && !i_cs_n && i_read_write_select)
			o_processor_data_oe_n <= 1'b0;
		else if (state == BUS_TAIL)
			o_processor_data_oe_n <= 1'b1;
	end

	// Read data latched once; holding select keeps it on the bus
	always_ff @(posedge i_mclk or negedge i_resetn)
	begin
		if (!i_resetn)
			o_processor_data_bus <= 16'h0000;
		else if (rd_op)
			o_processor_data_bus <= read_value;
	end

	// ----------------------------------------------------------------
	// Write permission decode
	// ----------------------------------------------------------------
	always_comb
	begin
		wr_ok      = 1'b0;
		mem_target = 1'b0;
		if (addr == ADDR_CONTROL_A)
			wr_ok = 1'b1;
		else if (addr == ADDR_SIGNAL_BITS_OUT || addr == ADDR_SIGNAL_BITS_CNT)
		begin
			wr_ok      = !i_conn.connection_signaling_active;
			mem_target = 1'b1;
		end
		else if (addr <= ADDR_MAX_NOISE_TIME)
		begin
			wr_ok      = 1'b1;
			mem_target = 1'b1;
		end
		else if (addr == ADDR_PHASE_TIMER_LOAD)
			wr_ok = i_conn.service_state;
		else if (addr == ADDR_NOISE_TIMER_LOAD)
			wr_ok = i_conn.service_state && !control_a[CA_NOISE_TIMING];
		else
			wr_ok = 1'b0;
	end

	assign wr_err   = wr_op && !wr_ok;
	assign mem_we   = wr_op && wr_ok && mem_target;
	// Read address must reach the store on the select edge itself
	assign mem_addr = (state == BUS_IDLE) ? i_processor_address[MEM_AW-1:0]
		: addr[MEM_AW-1:0];

	reg_store u_store
	(
		.i_mclk   (i_mclk),
		.i_resetn (i_resetn),
		.i_we     (mem_we),
		.i_addr   (mem_addr),
		.i_wdata  (i_processor_data_bus),
		.o_rdata  (mem_rdata)
	);

	// ----------------------------------------------------------------
	// Read data selection
	// ----------------------------------------------------------------
	always_comb
	begin
		if (addr == ADDR_CONTROL_A)
			read_value = control_a & CA_WRITABLE;
		else if (addr <= ADDR_MAX_NOISE_TIME)
			read_value = mem_rdata;
		else if (addr == ADDR_STATUS_A)
			read_value = i_ro.status_a;
		else if (addr == ADDR_STATUS_B)
			read_value = i_ro.status_b;
		else if (addr == ADDR_PHASE_TIMER_VAL)
			read_value = connection_phase_timer;
		else if (addr == ADDR_NOISE_TIMER_VAL)
			read_value = noise_event_timer;
		else if (addr == ADDR_CLOCK_DIVIDER)
			read_value = i_ro.clock_div;
		else if (addr == ADDR_SELF_TEST)
			read_value = i_ro.self_test;
		else if (addr == ADDR_SIGNAL_BITS_IN)
			read_value = i_ro.bits_in;
		else if (addr == ADDR_EVENT_FLAGS)
			read_value = event_flags;
		else if (addr == ADDR_VIOLATION_COUNT)
			read_value = violation_count;
		else if (addr == ADDR_IDLE_GAP_COUNT)
			read_value = idle_gap_count;
		else if (addr == ADDR_LINK_ERROR_COUNT)
			read_value = link_error_count;
		else
			read_value = 16'h0000;
	end

	// ----------------------------------------------------------------
	// Control register A
	// ----------------------------------------------------------------
	// Restricted bits keep their value unless the connection is off or
	// in service; the rest update on every write
	assign ca_keep = (i_conn.pcm_off || i_conn.service_state) ? 16'h0000 : CA_RESTRICTED;

	always_ff @(posedge i_mclk or negedge i_resetn)
	begin
		if (!i_resetn)
			control_a <= CA_RESET;
		else if (wr_op && addr == ADDR_CONTROL_A)
			control_a <= ((i_processor_data_bus & ~ca_keep) | (control_a & ca_keep))
				& CA_WRITABLE;
	end

	// Shadow of the maximum noise time for the noise timer
	always_ff @(posedge i_mclk or negedge i_resetn)
	begin
		if (!i_resetn)
			max_noise_time <= 16'h0000;
		else if (mem_we && addr == ADDR_MAX_NOISE_TIME)
			max_noise_time <= i_processor_data_bus;
	end

	// Path control outputs
	always_ff @(posedge i_mclk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			o_control_a     <= CA_RESET;
			o_rx_idle       <= 1'b0;
			o_wrap_select_n <= 1'b1;
		end
		else
		begin
			o_control_a     <= control_a;
			o_rx_idle       <= control_a[CA_SCRUB]
				&& (i_conn.service_state || i_conn.path_override_enable);
			o_wrap_select_n <= !control_a[CA_WRAP];
		end
	end

	// ----------------------------------------------------------------
	// Timer time base
	// ----------------------------------------------------------------
	// One pulse per 80 ns; prescalers are skipped in the wide modes
	always_ff @(posedge i_mclk or negedge i_resetn)
	begin
		if (!i_resetn)
			tick_cnt <= 4'h0;
		else if (tick)
			tick_cnt <= 4'h0;
		else
			tick_cnt <= tick_cnt + 4'h1;
	end

	assign tick = (tick_cnt == 4'(TICK_CYCLES - 1));

	always_ff @(posedge i_mclk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			noise_pre <= '0;
			phase_pre <= '0;
		end
		else if (tick)
		begin
			noise_pre <= noise_pre + 1'b1;
			phase_pre <= phase_pre + 1'b1;
		end
	end

	assign noise_step = tick && (control_a[CA_NOISE_WIDE] || (&noise_pre));
	assign phase_step = tick && (control_a[CA_PHASE_WIDE] || (&phase_pre));

	// ----------------------------------------------------------------
	// Connection phase timer
	// ----------------------------------------------------------------
	always_ff @(posedge i_mclk or negedge i_resetn)
	begin
		if (!i_resetn)
			connection_phase_timer <= 16'h0000;
		else if (wr_op && wr_ok && addr == ADDR_PHASE_TIMER_LOAD)
			connection_phase_timer <= i_processor_data_bus;
		else if (phase_step)
			connection_phase_timer <= connection_phase_timer + 16'h0001;
	end

	// ----------------------------------------------------------------
	// Noise event timer
	// ----------------------------------------------------------------
	// Line state comes from logic on this clock, so no synchroniser
	assign line_idle   = !i_unknown_line_state
		&& (i_line_state == LS_IDLE4 || i_line_state == LS_IDLE16);
	assign leave_idle  = prev_idle && (i_unknown_line_state
		|| i_line_state == LS_NOISE || i_line_state == LS_ACTIVE);
	assign noise_armed = control_a[CA_NOISE_TIMING] && i_conn.service_state;
	assign noise_expire = noise_run && noise_step && (&noise_event_timer);

	always_ff @(posedge i_mclk or negedge i_resetn)
	begin
		if (!i_resetn)
			prev_idle <= 1'b0;
		else
			prev_idle <= line_idle;
	end

	always_ff @(posedge i_mclk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			noise_event_timer <= 16'h0000;
			noise_run         <= 1'b0;
		end
		else if (noise_armed && leave_idle)
		begin
			noise_event_timer <= max_noise_time;
			noise_run         <= 1'b1;
		end
		else if (wr_op && wr_ok && addr == ADDR_NOISE_TIMER_LOAD)
			noise_event_timer <= i_processor_data_bus;
		else if (!noise_armed || line_idle || noise_expire)
			noise_run <= 1'b0;
		else if (noise_run && noise_step)
			noise_event_timer <= noise_event_timer + 16'h0001;
	end

	// ----------------------------------------------------------------
	// Error and idle counters, cleared on read
	// ----------------------------------------------------------------
	// A count arriving with the clearing read survives as one
	always_ff @(posedge i_mclk or negedge i_resetn)
	begin
		if (!i_resetn)
			violation_count <= 16'h0000;
		else if (rd_op && addr == ADDR_VIOLATION_COUNT)
			violation_count <= {15'h0000, i_violation_strobe};
		else if (i_violation_strobe)
			violation_count <= violation_count + 16'h0001;
	end

	always_ff @(posedge i_mclk or negedge i_resetn)
	begin
		if (!i_resetn)
			idle_gap_count <= 16'h0000;
		else if (rd_op && addr == ADDR_IDLE_GAP_COUNT)
			idle_gap_count <= {15'h0000, i_gap_strobe};
		else if (i_gap_strobe)
			idle_gap_count <= idle_gap_count + 16'h0001;
	end

	always_ff @(posedge i_mclk or negedge i_resetn)
	begin
		if (!i_resetn)
			link_error_count <= 16'h0000;
		else if (rd_op && addr == ADDR_LINK_ERROR_COUNT)
			link_error_count <= {15'h0000, i_link_error_strobe};
		else if (i_link_error_strobe)
			link_error_count <= link_error_count + 16'h0001;
	end

	// ----------------------------------------------------------------
	// Event flags
	// ----------------------------------------------------------------
	always_comb
	begin
		event_set = 16'h0000;
		event_set[EV_ACCESS_ERROR] = wr_err;
		event_set[EV_NOISE_EXPIRE] = noise_expire;
		event_set[EV_VIOLATION] = i_violation_strobe && (!control_a[CA_VIOL_OVF]
			|| violation_count[7:0] == VIOL_OVF_AT);
		event_set[EV_IDLE_GAP] = i_gap_strobe && (!control_a[CA_GAP_OVF]
			|| idle_gap_count[3:0] == GAP_OVF_AT);
		event_set[EV_PARITY] = i_tx_valid && control_a[CA_PARITY] && (^i_tx_byte);
	end

	// Set wins over the clearing read
	always_ff @(posedge i_mclk or negedge i_resetn)
	begin
		if (!i_resetn)
			event_flags <= 16'h0000;
		else if (rd_op && addr == ADDR_EVENT_FLAGS)
			event_flags <= event_set;
		else
			event_flags <= event_flags | event_set;
	end

endmodule

/* File: src/npr_pkg.sv */
// Constants, layouts and carrier types for the node processor register port.
// Assumes a single 100 MHz clock shared with the processor bus.
package npr_pkg;

	// ----------------------------------------------------------------
	// Widths and register offsets
	// ----------------------------------------------------------------
	localparam int unsigned ADDR_W = 5;
	localparam int unsigned DATA_W = 16;
	localparam int unsigned MEM_AW = 4;

	localparam logic [4:0] ADDR_CONTROL_A        = 5'h00;
	localparam logic [4:0] ADDR_CONTROL_B        = 5'h01;
	localparam logic [4:0] ADDR_EVENT_MASK       = 5'h02;
	localparam logic [4:0] ADDR_SIGNAL_BITS_OUT  = 5'h03;
	localparam logic [4:0] ADDR_SIGNAL_BITS_CNT  = 5'h04;
	localparam logic [4:0] ADDR_MAX_NOISE_TIME   = 5'h0d;
	localparam logic [4:0] ADDR_PHASE_TIMER_LOAD = 5'h0e;
	localparam logic [4:0] ADDR_NOISE_TIMER_LOAD = 5'h0f;
	localparam logic [4:0] ADDR_STATUS_A         = 5'h10;
	localparam logic [4:0] ADDR_STATUS_B         = 5'h11;
	localparam logic [4:0] ADDR_PHASE_TIMER_VAL  = 5'h12;
	localparam logic [4:0] ADDR_NOISE_TIMER_VAL  = 5'h13;
	localparam logic [4:0] ADDR_CLOCK_DIVIDER    = 5'h14;
	localparam logic [4:0] ADDR_SELF_TEST        = 5'h15;
	localparam logic [4:0] ADDR_SIGNAL_BITS_IN   = 5'h16;
	localparam logic [4:0] ADDR_EVENT_FLAGS      = 5'h17;
	localparam logic [4:0] ADDR_VIOLATION_COUNT  = 5'h18;
	localparam logic [4:0] ADDR_IDLE_GAP_COUNT   = 5'h19;
	localparam logic [4:0] ADDR_LINK_ERROR_COUNT = 5'h1a;

	// ----------------------------------------------------------------
	// Control register A fields
	// ----------------------------------------------------------------
	localparam int unsigned CA_NOISE_TIMING = 14;
	localparam int unsigned CA_NOISE_WIDE   = 13;
	localparam int unsigned CA_PHASE_WIDE   = 12;
	localparam int unsigned CA_SCRUB        = 11;
	localparam int unsigned CA_PARITY       = 10;
	localparam int unsigned CA_VIOL_OVF     = 9;
	localparam int unsigned CA_GAP_OVF      = 8;
	localparam int unsigned CA_WRAP         = 7;
	localparam logic [15:0] CA_RESET        = 16'h0000;
	localparam logic [15:0] CA_WRITABLE     = 16'h7fff;
	localparam logic [15:0] CA_RESTRICTED   = 16'h3030;

	// ----------------------------------------------------------------
	// Event flag positions
	// ----------------------------------------------------------------
	localparam int unsigned EV_ACCESS_ERROR = 0;
	localparam int unsigned EV_NOISE_EXPIRE = 1;
	localparam int unsigned EV_VIOLATION    = 2;
	localparam int unsigned EV_IDLE_GAP     = 3;
	localparam int unsigned EV_PARITY       = 4;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_MHZ       = 100;
	localparam int unsigned TICK_NS       = 80;
	localparam int unsigned TICK_CYCLES   = (TICK_NS * CLK_MHZ) / 1000;
	localparam int unsigned NOISE_PRE_W   = 2;
	localparam int unsigned PHASE_PRE_W   = 8;
	localparam logic [7:0]  VIOL_OVF_AT   = 8'hff;
	localparam logic [3:0]  GAP_OVF_AT    = 4'hf;

	// ----------------------------------------------------------------
	// Line state codes
	// ----------------------------------------------------------------
	localparam logic [2:0] LS_NOISE  = 3'h0;
	localparam logic [2:0] LS_ACTIVE = 3'h1;
	localparam logic [2:0] LS_IDLE4  = 3'h3;
	localparam logic [2:0] LS_IDLE16 = 3'h7;

	// ----------------------------------------------------------------
	// Carriers and states
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [15:0] status_a;
		logic [15:0] status_b;
		logic [15:0] clock_div;
		logic [15:0] self_test;
		logic [15:0] bits_in;
	} ro_inputs_t;

	typedef struct packed {
		logic pcm_off;
		logic service_state;
		logic connection_signaling_active;
		logic path_override_enable;
	} conn_state_t;

	typedef enum logic [1:0] {BUS_IDLE, BUS_ACCESS, BUS_HELD, BUS_TAIL} bus_state_t;

endpackage

/* File: src/reg_store.sv */
// Small register store for the plain read/write words.
// Assumes one writer and one reader on the same clock; read data registered.
`timescale 1ns/1ns
module reg_store
(
	input  wire logic                      i_mclk,
	input  wire logic                      i_resetn,
	input  wire logic                      i_we,
	input  wire logic [npr_pkg::MEM_AW-1:0] i_addr,
	input  wire logic [npr_pkg::DATA_W-1:0] i_wdata,
	output logic      [npr_pkg::DATA_W-1:0] o_rdata
);
	import npr_pkg::*;

	logic [DATA_W-1:0] words [2**MEM_AW];

	// ----------------------------------------------------------------
	// Storage, cleared by reset like every writable register
	// ----------------------------------------------------------------
	for (genvar k = 0; k < 2**MEM_AW; k++)
	begin : g_word
		always_ff @(posedge i_mclk or negedge i_resetn)
		begin
			if (!i_resetn)
				words[k] <= 16'h0000;
			else if (i_we && i_addr == MEM_AW'(k))
				words[k] <= i_wdata;
		end
	end

	// Registered read port
	always_ff @(posedge i_mclk or negedge i_resetn)
	begin
		if (!i_resetn)
			o_rdata <= 16'h0000;
		else
			o_rdata <= words[i_addr];
	end

endmodule

/* File: verification/npr_host.sv */
// Node processor model: bus master of the register port.
// Assumes the port samples select on the rising edge of the shared clock.
`timescale 1ns/1ns
module npr_host
(
	input  wire logic        i_mclk,
	input  wire logic [15:0] i_rdata,
	output logic             o_cs_n,
	output logic             o_rw,
	output logic [4:0]       o_addr,
	output logic [15:0]      o_data
);
	// Idle bus: deselected, data line shows a pattern
	initial
	begin
		o_cs_n = 1'b1;
		o_rw = 1'b1;
		o_addr = 5'h00;
		o_data = 16'h5a5a;
	end

	// ----------------------------------------------------------------
	// One cycle per call, select held for extra edges on request
	// ----------------------------------------------------------------
	task automatic access(input logic rw, input logic [4:0] a, input logic [15:0] d,
		input int hold, output logic [15:0] q);
	begin
		@(posedge i_mclk);
		o_cs_n <= 1'b0;
		o_rw <= rw;
		o_addr <= a;
		o_data <= d;
		@(posedge i_mclk);
		// Data past the capture edge changes, so a second write would show
		repeat (hold)
		begin
			@(posedge i_mclk);
			o_data <= ~d;
		end
		o_cs_n <= 1'b1;
		@(posedge i_mclk);
		#1 q = i_rdata;
		@(posedge i_mclk);
		// Released data must not look like the last word
		o_data <= ~d;
	end
	endtask
endmodule

/* File: verification/npr_properties.sv */
// Pin-level checks for the register port.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/1ns
module npr_properties
(
	input wire logic                 i_mclk,
	input wire logic                 i_resetn,
	input wire logic                 i_cs_n,
	input wire logic                 i_read_write_select,
	input wire npr_pkg::conn_state_t i_conn,
	input wire logic                 o_processor_data_oe_n,
	input wire logic [15:0]          o_control_a,
	input wire logic                 o_wrap_select_n
);
	import npr_pkg::*;
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_resetn);

	// ----------------------------------------------------------------
	// Control outputs
	// ----------------------------------------------------------------
	reset_val_a: assert property ($rose(i_resetn) |-> o_processor_data_oe_n
		&& o_wrap_select_n && o_control_a == 16'h0000) else $error("not at reset values");
	bit15_zero_a: assert property (o_control_a[15] == 1'b0)
		else $error("reserved bit set");
	wrap_follow_a: assert property (o_wrap_select_n == !o_control_a[7])
		else $error("wrap select wrong");
	// A late write to restricted bits would show here one cycle on
	restrict_hold_a: assert property ($past(!i_conn.pcm_off && !i_conn.service_state)
		|-> $stable(o_control_a & CA_RESTRICTED)) else $error("restricted bits moved");

	// ----------------------------------------------------------------
	// Data bus drive
	// ----------------------------------------------------------------
	read_drive_a: assert property (o_processor_data_oe_n && !i_cs_n && i_read_write_select
		|=> !o_processor_data_oe_n) else $error("read not driven");
	write_quiet_a: assert property (o_processor_data_oe_n && !i_cs_n && !i_read_write_select
		|=> o_processor_data_oe_n ##1 o_processor_data_oe_n) else $error("write drove bus");
	read_hold_a: assert property ($fell(o_processor_data_oe_n) |-> !o_processor_data_oe_n[*2])
		else $error("read data dropped early");
	bus_release_a: assert property (!o_processor_data_oe_n && i_cs_n ##1 i_cs_n
		|=> o_processor_data_oe_n) else $error("bus not released");
endmodule

bind node_processor_register_port npr_properties chk (.i_mclk(i_mclk), .i_resetn(i_resetn),
	.i_cs_n(i_cs_n), .i_read_write_select(i_read_write_select), .i_conn(i_conn),
	.o_processor_data_oe_n(o_processor_data_oe_n), .o_control_a(o_control_a),
	.o_wrap_select_n(o_wrap_select_n));

/* File: verification/tb_node_processor_register_port.sv */
// Self-checking bench for the register port.
// Assumes npr_host drives the bus and npr_properties is bound to the port.
`timescale 1ns/1ns
module tb_node_processor_register_port;
	import npr_pkg::*;
	logic        i_mclk = 1'b0;
	logic        i_resetn = 1'b0;
	logic        cs_n, rw, oe_n, rx_idle, wrap_n;
	logic [4:0]  addr;
	logic [15:0] host_d, dut_d, bus, ctl_a, q;
	conn_state_t conn = '0;
	ro_inputs_t  ro = {16'h1234, 64'h0};
	logic        viol = 1'b0, gap = 1'b0, lerr = 1'b0, tx_v = 1'b0;
	logic [9:0]  tx_b = 10'h000;
	logic [2:0]  ls = LS_IDLE16;
	logic        unk = 1'b0;
	int          fail_count = 0, samples_checked = 0, cycles = 0;

	// Shared data wire: whoever is enabled owns it
	assign bus = oe_n ? host_d : dut_d;
	always #5 i_mclk = ~i_mclk;

	npr_host host (.i_mclk(i_mclk), .i_rdata(bus), .o_cs_n(cs_n), .o_rw(rw),
		.o_addr(addr), .o_data(host_d));
	node_processor_register_port DUT (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_cs_n(cs_n),
		.i_read_write_select(rw), .i_processor_address(addr), .i_processor_data_bus(bus),
		.o_processor_data_bus(dut_d), .o_processor_data_oe_n(oe_n), .i_conn(conn),
		.i_ro(ro), .i_line_state(ls), .i_unknown_line_state(unk),
		.i_violation_strobe(viol), .i_gap_strobe(gap), .i_link_error_strobe(lerr),
		.i_tx_valid(tx_v), .i_tx_byte(tx_b), .o_control_a(ctl_a), .o_rx_idle(rx_idle),
		.o_wrap_select_n(wrap_n));

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic end_of_test;
	begin
		if (fail_count == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	end
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
	begin
		samples_checked++;
		if (got !== exp)
		begin
			fail_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	end
	endtask
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
	begin
		host.access(1'b0, a, d, 0, q);
	end
	endtask
	task automatic rd(input logic [4:0] a, input logic [15:0] e);
	begin
		host.access(1'b1, a, 16'h0000, 0, q);
		chk(q, e);
	end
	endtask
	task automatic set_conn(input logic [3:0] v);
	begin
		@(posedge i_mclk);
		conn <= v;
	end
	endtask
	// Strobes spaced apart so each counts once
	task automatic pulse(input int n);
	begin
		repeat (n)
		begin
			@(posedge i_mclk);
			{viol, gap, lerr} <= 3'b111;
			@(posedge i_mclk);
			{viol, gap, lerr} <= 3'b000;
		end
	end
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_control;
	begin
		rd(ADDR_CONTROL_A, 16'h0000);
		wr(ADDR_CONTROL_A, 16'hffff);
		rd(ADDR_CONTROL_A, 16'h4fcf);
		chk({14'h0, wrap_n, rx_idle}, 16'h0000);
		set_conn(4'b0100);
		wr(ADDR_CONTROL_A, 16'hffff);
		rd(ADDR_CONTROL_A, 16'h7fff);
		chk({15'h0, rx_idle}, 16'h0001);
		wr(ADDR_NOISE_TIMER_LOAD, 16'h0100);
		rd(ADDR_EVENT_FLAGS, 16'h0001);
		wr(ADDR_CONTROL_A, 16'h0000);
		wr(ADDR_PHASE_TIMER_LOAD, 16'h0100);
		wr(ADDR_NOISE_TIMER_LOAD, 16'h0100);
		rd(ADDR_EVENT_FLAGS, 16'h0000);
		set_conn(4'b0000);
		wr(ADDR_PHASE_TIMER_LOAD, 16'h0100);
		rd(ADDR_EVENT_FLAGS, 16'h0001);
	end
	endtask
	task automatic t_guard;
	begin
		set_conn(4'b0010);
		wr(ADDR_SIGNAL_BITS_OUT, 16'habcd);
		rd(ADDR_EVENT_FLAGS, 16'h0001);
		rd(ADDR_SIGNAL_BITS_OUT, 16'h0000);
		set_conn(4'b0000);
		wr(ADDR_SIGNAL_BITS_OUT, 16'habcd);
		rd(ADDR_SIGNAL_BITS_OUT, 16'habcd);
		wr(ADDR_STATUS_A, 16'hffff);
		rd(ADDR_EVENT_FLAGS, 16'h0001);
		rd(ADDR_STATUS_A, 16'h1234);
		rd(ADDR_EVENT_FLAGS, 16'h0000);
		rd(5'h1b, 16'h0000);
		wr(5'h1c, 16'h0001);
		rd(ADDR_EVENT_FLAGS, 16'h0001);
	end
	endtask
	task automatic t_count;
	begin
		pulse(3);
		rd(ADDR_EVENT_FLAGS, 16'h000c);
		for (int i = 0; i < 3; i++)
		begin
			rd(ADDR_VIOLATION_COUNT + 5'(i), 16'h0003);
			rd(ADDR_VIOLATION_COUNT + 5'(i), 16'h0000);
		end
		wr(ADDR_CONTROL_A, 16'h0200);
		pulse(3);
		rd(ADDR_EVENT_FLAGS, 16'h0008);
		// Counts stand at 3: the 13th strobe wraps the gap nibble
		wr(ADDR_CONTROL_A, 16'h0300);
		pulse(13);
		rd(ADDR_EVENT_FLAGS, 16'h0008);
		pulse(239);
		rd(ADDR_EVENT_FLAGS, 16'h0008);
		pulse(1);
		rd(ADDR_EVENT_FLAGS, 16'h000c);
	end
	endtask
	// Odd-weight byte with checking on flags a parity event
	task automatic t_parity;
	begin
		wr(ADDR_CONTROL_A, 16'h0400);
		@(posedge i_mclk);
		tx_b <= 10'h001;
		tx_v <= 1'b1;
		@(posedge i_mclk);
		tx_v <= 1'b0;
		rd(ADDR_EVENT_FLAGS, 16'h0010);
	end
	endtask

	// Held select: one write only, read data stands until release
	task automatic t_held;
	begin
		host.access(1'b0, ADDR_SIGNAL_BITS_CNT, 16'h1357, 3, q);
		rd(ADDR_SIGNAL_BITS_CNT, 16'h1357);
		host.access(1'b1, ADDR_SIGNAL_BITS_CNT, 16'h0000, 2, q);
		chk(q, 16'h1357);
	end
	endtask
	// Wide noise timer from fff0 expires in 16 ticks; idle first stops it
	task automatic t_noise;
	begin
		set_conn(4'b0100);
		wr(ADDR_MAX_NOISE_TIME, 16'hfff0);
		wr(ADDR_CONTROL_A, 16'h6000);
		@(posedge i_mclk);
		ls <= LS_NOISE;
		repeat (150) @(posedge i_mclk);
		rd(ADDR_EVENT_FLAGS, 16'h0002);
		ls <= LS_IDLE4;
		repeat (2) @(posedge i_mclk);
		unk <= 1'b1;
		repeat (20) @(posedge i_mclk);
		unk <= 1'b0;
		repeat (150) @(posedge i_mclk);
		rd(ADDR_EVENT_FLAGS, 16'h0000);
	end
	endtask

	// Hang guard, well above the thousand or so cycles needed
	always @(posedge i_mclk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			fail_count++;
			end_of_test();
		end
	end

	initial
	begin
		repeat (20) @(posedge i_mclk);
		i_resetn <= 1'b1;
		t_control();
		t_guard();
		t_count();
		t_parity();
		t_held();
		t_noise();
		end_of_test();
	end
endmodule
